// ---- logic/spis_irq_id_regs.sv ----
`timescale 1ns/1ps
`include "spis_regs.svh"
// interrupt status, mask, clear and identification registers on wishbone
module spis_irq_id_regs
#(
	parameter logic [7:0] ID_LOW0 = 8'h5A, // arbitrary
	parameter logic [7:0] ID_LOW1 = 8'h3C, // arbitrary
	parameter logic [7:0] ID_LOW2 = 8'h96, // arbitrary
	parameter logic [7:0] ID_EXT0 = 8'hA5, // arbitrary
	parameter logic [7:0] ID_EXT1 = 8'hC3, // arbitrary
	parameter logic [7:0] ID_EXT2 = 8'h69, // arbitrary
	parameter logic [7:0] ID_EXT3 = 8'h0F // arbitrary
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic txFifoHalfOrLess,
	input wire logic rxFifoHalfOrMore,
	input wire logic rxTimeoutEvent,
	input wire logic rxOverrunEvent,
	output logic [3:0] irqMask,
	output logic irqOut
);
	spis_pkg::spis_bus_t busState_reg;
	spis_pkg::spis_bus_t busState_next;
	logic [31:0] rdData_reg;
	logic [31:0] rdData_next;
	logic errFlag_reg;
	logic [3:0] mask_reg;
	logic [3:0] mask_next;
	logic [1:0] sticky_reg;
	logic [1:0] sticky_next;
	logic txLevel;
	logic rxLevel;
	logic rtPulse;
	logic rorPulse;
	logic [3:0] rawStatus;
	logic [3:0] maskedStatus;
	logic [11:0] offset;
	logic request;
	logic accept;
	logic wrAccept;
	logic lane0;
	logic hitMask;
	logic hitRaw;
	logic hitMis;
	logic hitIcr;
	logic hitId;
	logic hitAny;
	logic [1:0] clearBits;
	logic [31:0] readMux;

	// zero-extends a byte-wide field into a bus word; upper bits read zero
	function automatic logic [31:0] spis_word(input logic [7:0] v);
		spis_word = {24'h000000, v};
	endfunction

	spis_event_sync uTxSync (
		.clk_sys(clk_sys),
		.rst(rst),
		.eventPin(txFifoHalfOrLess),
		.eventLevel(txLevel),
		.eventPulse()
	);
	spis_event_sync uRxSync (
		.clk_sys(clk_sys),
		.rst(rst),
		.eventPin(rxFifoHalfOrMore),
		.eventLevel(rxLevel),
		.eventPulse()
	);
	spis_event_sync uRtSync (
		.clk_sys(clk_sys),
		.rst(rst),
		.eventPin(rxTimeoutEvent),
		.eventLevel(),
		.eventPulse(rtPulse)
	);
	spis_event_sync uRorSync (
		.clk_sys(clk_sys),
		.rst(rst),
		.eventPin(rxOverrunEvent),
		.eventLevel(),
		.eventPulse(rorPulse)
	);

	// fifo level flags follow the port through the two-flop synchroniser; the two receive events
	// are sticky until software clears them
	assign rawStatus[`SPIS_BIT_TX] = txLevel;
	assign rawStatus[`SPIS_BIT_RX] = rxLevel;
	assign rawStatus[`SPIS_BIT_RT] = sticky_reg[`SPIS_BIT_RT];
	assign rawStatus[`SPIS_BIT_ROR] = sticky_reg[`SPIS_BIT_ROR];
	assign maskedStatus = rawStatus & mask_reg;
	assign irqOut = |maskedStatus;
	assign irqMask = mask_reg;

	assign offset = wb_adr_i[11:0];
	assign request = wb_cyc_i & wb_stb_i;
	assign accept = request & (busState_reg == spis_pkg::SPIS_IDLE);
	assign wrAccept = accept & wb_we_i & hitAny;
	assign lane0 = wb_sel_i[0];

	assign hitMask = (offset == `SPIS_OFF_MASK);
	assign hitRaw = (offset == `SPIS_OFF_RAW);
	assign hitMis = (offset == `SPIS_OFF_MIS);
	assign hitIcr = (offset == `SPIS_OFF_ICR);
	assign hitId = (offset == `SPIS_OFF_EXT0) | (offset == `SPIS_OFF_EXT1)
		| (offset == `SPIS_OFF_EXT2) | (offset == `SPIS_OFF_EXT3)
		| (offset == `SPIS_OFF_LOW0) | (offset == `SPIS_OFF_LOW1)
		| (offset == `SPIS_OFF_LOW2);
	assign hitAny = (wb_adr_i[31:12] == 20'h00000)
		& (hitMask | hitRaw | hitMis | hitIcr | hitId);

	// only a one in the low two bits clears; zeros and upper bits do nothing
	assign clearBits = (wrAccept & hitIcr & lane0)
		? wb_dat_i[`SPIS_CLR_BITS-1:0] : 2'h0;

	// status, raw, id and mask reads; reserved bits are zero
	assign readMux =
		(wb_adr_i[31:12] != 20'h00000) ? 32'h00000000 :
		hitMask ? {28'h0000000, mask_reg} :
		hitRaw ? {28'h0000000, rawStatus} :
		hitMis ? {28'h0000000, maskedStatus} :
		(offset == `SPIS_OFF_EXT0) ? spis_word(ID_EXT0) :
		(offset == `SPIS_OFF_EXT1) ? spis_word(ID_EXT1) :
		(offset == `SPIS_OFF_EXT2) ? spis_word(ID_EXT2) :
		(offset == `SPIS_OFF_EXT3) ? spis_word(ID_EXT3) :
		(offset == `SPIS_OFF_LOW0) ? spis_word(ID_LOW0) :
		(offset == `SPIS_OFF_LOW1) ? spis_word(ID_LOW1) :
		(offset == `SPIS_OFF_LOW2) ? spis_word(ID_LOW2) :
		32'h00000000;

	// one-cycle answer, then one idle cycle so ack falls after each access
	always_comb
	begin
		busState_next = spis_pkg::SPIS_IDLE;
		case (busState_reg)
			spis_pkg::SPIS_IDLE:
			begin
				if (request)
					busState_next = spis_pkg::SPIS_ACK;
			end
			spis_pkg::SPIS_ACK:
			begin
				busState_next = spis_pkg::SPIS_IDLE;
			end
			default:
			begin
				busState_next = spis_pkg::SPIS_IDLE;
			end
		endcase
	end

	assign rdData_next = (accept & ~wb_we_i) ? readMux : rdData_reg;

	// mask writes use the low byte lane; writes to masked status, raw status
	// and id words touch nothing
	assign mask_next = (wrAccept & hitMask & lane0)
		? wb_dat_i[`SPIS_NIRQ-1:0] : mask_reg;

	// a new event in the clearing cycle wins over the clear
	assign sticky_next = (sticky_reg & ~clearBits)
		| {rtPulse, rorPulse};

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			busState_reg <= spis_pkg::SPIS_IDLE;
			rdData_reg <= 32'h00000000;
			errFlag_reg <= 1'b0;
			mask_reg <= `SPIS_MASK_RST;
			sticky_reg <= `SPIS_STICKY_RST;
		end
		else
		begin
			busState_reg <= busState_next;
			rdData_reg <= rdData_next;
			errFlag_reg <= accept & ~hitAny;
			mask_reg <= mask_next;
			sticky_reg <= sticky_next;
		end
	end

	assign wb_ack_o = (busState_reg == spis_pkg::SPIS_ACK) & ~errFlag_reg
		& wb_cyc_i & wb_stb_i;
	assign wb_err_o = (busState_reg == spis_pkg::SPIS_ACK) & errFlag_reg
		& wb_cyc_i & wb_stb_i;
	assign wb_dat_o = rdData_reg;
endmodule

// ---- logic/spis_regs.svh ----
// register offsets, field positions and reset values of the serial port irq/id block
`ifndef SPIS_REGS_SVH
`define SPIS_REGS_SVH
`define SPIS_ADDR_W 12
`define SPIS_OFF_MASK 12'h014
`define SPIS_OFF_RAW 12'h018
`define SPIS_OFF_MIS 12'h01C
`define SPIS_OFF_ICR 12'h020
`define SPIS_OFF_EXT0 12'hFD0
`define SPIS_OFF_EXT1 12'hFD4
`define SPIS_OFF_EXT2 12'hFD8
`define SPIS_OFF_EXT3 12'hFDC
`define SPIS_OFF_LOW0 12'hFE0
`define SPIS_OFF_LOW1 12'hFE4
`define SPIS_OFF_LOW2 12'hFE8
`define SPIS_NIRQ 4
`define SPIS_BIT_TX 3
`define SPIS_BIT_RX 2
`define SPIS_BIT_RT 1
`define SPIS_BIT_ROR 0
`define SPIS_MASK_RST 4'h0
`define SPIS_STICKY_RST 2'h0
`define SPIS_CLR_BITS 2
`define SPIS_ID_W 8
`endif

// ---- logic/spis_pkg.sv ----
// types shared by the serial port irq/id register block
package spis_pkg;
	typedef enum logic [0:0] {SPIS_IDLE = 1'b0, SPIS_ACK = 1'b1} spis_bus_t;
endpackage

// ---- logic/spis_event_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser plus rising-edge pulse for one event pin
module spis_event_sync
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic eventPin,
	output logic eventLevel,
	output logic eventPulse
);
	logic stage1_reg;
	logic stage2_reg;
	logic stage3_reg;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
			stage3_reg <= 1'b0;
		end
		else
		begin
			stage1_reg <= eventPin;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end
	assign eventLevel = stage2_reg;
	assign eventPulse = stage2_reg & ~stage3_reg;
endmodule

// ---- dv/spis_irq_id_regs_properties.sv ----
`timescale 1ns/1ps
`include "spis_regs.svh"
// port assertions for the irq status and id registers
module spis_irq_id_regs_properties
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic txFifoHalfOrLess,
	input wire logic [3:0] irqMask,
	input wire logic irqOut
);
	logic req;
	logic rdAck;
	logic [11:0] off;
	// upper address bits must be zero or the request is refused
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~|wb_adr_i[31:12];
	assign rdAck = wb_ack_o & ~wb_we_i;
	assign off = wb_adr_i[11:0];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_mask_reset: assert property ($fell(rst) |-> irqMask == 4'h0)
		else $error("mask not clear");
	a_mask_write: assert property (
		req && wb_we_i && wb_sel_i[0] && off == `SPIS_OFF_MASK
		|=> irqMask == wb_dat_i[3:0]) else $error("mask write lost");
	a_mask_read: assert property (
		rdAck && off == `SPIS_OFF_MASK |-> wb_dat_o == {28'h0, irqMask})
		else $error("mask read");
	a_status_ro: assert property (
		req && wb_we_i && off == `SPIS_OFF_MIS |=> $stable(irqMask))
		else $error("status write");
	a_status_gated: assert property (
		rdAck && off == `SPIS_OFF_MIS |-> wb_dat_o[31:4] == 28'h0
		&& (wb_dat_o[3:0] & ~irqMask) == 4'h0) else $error("status mask");
	a_id_byte: assert property (
		rdAck && off[11:8] == 4'hF |-> wb_dat_o[31:8] == 24'h0)
		else $error("id upper bits");
	a_irq_cause: assert property (irqOut |-> irqMask != 4'h0)
		else $error("irq masked");
	a_tx_irq: assert property (
		(txFifoHalfOrLess && irqMask[3]) [*4] |-> irqOut)
		else $error("tx irq missing");
endmodule
bind spis_irq_id_regs spis_irq_id_regs_properties chk (.*);

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
// bench for the irq status and id registers
module testbench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [31:0] wb_adr_i = 32'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic wb_err_o;
	logic [3:0] evPins = 4'h0;
	logic [3:0] irqMask;
	logic irqOut;
	logic [31:0] rdat;
	int fails = 0;
	int cmp_count = 0;
	logic [7:0] ids [7] = '{8'hA5, 8'hC3, 8'h69, 8'h0F, 8'h5A, 8'h3C, 8'h96};
	always #25 clk_sys = ~clk_sys;
	spis_irq_id_regs uut (.*, .txFifoHalfOrLess(evPins[3]),
		.rxFifoHalfOrMore(evPins[2]), .rxTimeoutEvent(evPins[1]),
		.rxOverrunEvent(evPins[0]));
	task automatic check(string nm, logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
		wb_adr_i <= {20'h0, a};
		wb_dat_i <= d;
		for (n = 0; n < 20 && wb_ack_o !== 1'b1 && wb_err_o !== 1'b1; n++)
			@(posedge clk_sys);
		if (n == 20)
		begin
			fails++;
			give_verdict();
		end
		// an error answer leaves all ones, so refusals compare like reads
		rdat = wb_ack_o ? wb_dat_o : 32'hFFFFFFFF;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		@(posedge clk_sys);
	endtask
	task automatic rd(logic [11:0] a, logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check($sformatf("offset %h", a), rdat, e);
	endtask
	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd(12'h014, 32'h0);
		for (int i = 0; i < 7; i++)
			rd(12'hFD0 + 12'(4 * i), {24'h0, ids[i]});
		bus(1'b1, 12'hFE0, 32'hFFFFFFFF);
		rd(12'hFE0, 32'h0000005A);
		rd(12'h100, 32'hFFFFFFFF);
		$display("id test done");
		evPins <= 4'hF;
		repeat (5) @(posedge clk_sys);
		evPins <= 4'hC;
		bus(1'b1, 12'h014, 32'hFFFFFFF9);
		// a write without the low byte lane must leave the mask alone
		wb_sel_i <= 4'hE;
		bus(1'b1, 12'h014, 32'h00000006);
		wb_sel_i <= 4'hF;
		rd(12'h014, 32'h00000009);
		bus(1'b1, 12'h01C, 32'h0);
		bus(1'b1, 12'h020, 32'hFFFFFFFC);
		rd(12'h018, 32'h0000000F);
		rd(12'h01C, 32'h00000009);
		bus(1'b1, 12'h020, 32'h00000001);
		rd(12'h01C, 32'h00000008);
		bus(1'b1, 12'h020, 32'h00000002);
		rd(12'h018, 32'h0000000C);
		check("irq", {31'h0, irqOut}, 32'h1);
		bus(1'b1, 12'h014, 32'h0);
		check("irq", {31'h0, irqOut}, 32'h0);
		$display("irq test done");
		give_verdict();
	end
endmodule
